/* File: esr_pkg.sv */
/*
  Constants, types and register map of the embedded-operation suspend/resume sequencer.
  Assumes a single-bit serial link and an Avalon-MM slave port with byte addresses.
*/
`default_nettype none
package esr_pkg;
  // Register map (byte offsets)
  localparam int          ADDR_W      = 5;
  localparam int          DATA_W      = 32;
  localparam logic [4:0]  REG_STATUS1 = 5'h00;
  localparam logic [4:0]  REG_STATUS2 = 5'h04;
  localparam logic [4:0]  REG_IRQSTAT = 5'h08;
  localparam logic [4:0]  REG_IRQMASK = 5'h0C;
  localparam logic [4:0]  REG_OPLEN   = 5'h10;
  localparam logic [4:0]  REG_LASTCMD = 5'h14;
  // Field positions
  localparam int          RDY_BIT     = 0;
  localparam int          PROG_BIT    = 0;
  localparam int          ERASE_BIT   = 1;
  localparam int          DIC_BIT     = 4;
  localparam int          ARMED_BIT   = 8;
  localparam int          IRQ_DONE    = 0;
  localparam int          IRQ_REJECT  = 1;
  localparam int          IRQ_IGNORE  = 2;
  localparam int          IRQ_SUSP    = 3;
  localparam int          IRQ_W       = 4;
  // Reset values
  localparam logic [15:0] OPLEN_RST   = 16'h0100;
  localparam logic [3:0]  MASK_RST    = 4'h0;
  // Serial framing
  localparam logic [3:0]  OPC_BITS    = 4'h8;
  localparam logic [3:0]  CNT_MAX     = 4'hF;
  // Transaction opcodes (values are arbitrary)
  localparam logic [7:0]  SUSPEND_ALL_OPS_CMD   = 8'h01;
  localparam logic [7:0]  RESUME_ALL_OPS_CMD    = 8'h02;
  localparam logic [7:0]  SUSPEND_PROG_ERASE_CMD = 8'h03;
  localparam logic [7:0]  RESUME_PROG_ERASE_CMD = 8'h04;
  localparam logic [7:0]  PROGRAM_CMD           = 8'h10;
  localparam logic [7:0]  SECTOR_ERASE_CMD      = 8'h11;
  localparam logic [7:0]  INTEGRITY_CHECK_CMD   = 8'h12;
  localparam logic [7:0]  WRITE_REG_CMD         = 8'h13;
  localparam logic [7:0]  PPB_ERASE_CMD         = 8'h14;
  localparam logic [7:0]  SOFT_RESET_ENABLE_CMD = 8'h20;
  localparam logic [7:0]  READ_DYNAMIC_PROTECT_CMD = 8'h21;
  localparam logic [7:0]  FAST_READ_SHORT_CMD   = 8'h22;
  localparam logic [7:0]  FAST_READ_LONG_CMD    = 8'h23;
  localparam logic [7:0]  LEARNING_PATTERN_READ_CMD = 8'h24;
  localparam logic [7:0]  QUAD_IDENTITY_READ_CMD = 8'h25;
  localparam logic [7:0]  READ_STATUS1_CMD      = 8'h26;
  localparam logic [7:0]  READ_STATUS2_CMD      = 8'h27;

  typedef enum logic [1:0] {ESR_IDLE, ESR_PROG, ESR_ERASE, ESR_DIC} esr_op_t;
  typedef struct packed {
    logic dic;
    logic erase;
    logic prog;
  } esr_susp_t;
  typedef struct packed {
    logic sclk;
    logic csN;
    logic mosi;
  } esr_spi_t;
endpackage
`default_nettype wire

/* File: esr_suspend_resume.sv */
/*
  Suspend/resume sequencer for program, sector erase and integrity check operations.
  Assumes serial link pins from another clock domain and an Avalon-MM master on clk.
*/
// Functional notes
// - A suspended operation stays suspended until a resume transaction arrives.
// - Accepted resume sets ready/busy to 1 and restarts suspended work.
// - Resume restarts a suspended program before a suspended erase.
// - Resume with nothing suspended is discarded; it sets the ignore event flag and clears the software reset arming.
// - Any number of suspend/resume cycles, back to back, is accepted.
// - Two pairs: one covers all three operations, one program and erase only.
// - Suspends of either variant are rejected while program or check suspended.
// - Soft reset enable is accepted during program or check suspend.
// - Dynamic protection read is accepted during check suspend.
// - Fast single-rate read, both address lengths, accepted during program suspend.
// - Learning pattern read is accepted during every kind of suspend.
// - Quad identity read is accepted during erase suspend.
// - Ready/busy is status one bit 0, high while an operation runs.
// - Status two holds program, erase and check suspended flags in bits 0,1,4.
// - New erase transactions are ignored during any suspend.
// - Register writes and protection bit erase are rejected during any suspend.
`timescale 1ns/1ps
`default_nettype none
module esr_suspend_resume #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // Avalon-MM slave
  input  wire logic [esr_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [esr_pkg::DATA_W-1:0]    avs_writedata,
  output logic      [esr_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // Serial link
  input  wire esr_pkg::esr_spi_t             spiIn,
  output logic                               spiMiso,
  // Interrupt
  output logic                               irq
);
  import esr_pkg::*;

  esr_spi_t           sync1_reg, sync2_reg, prev_reg;
  logic [3:0]         bitCnt_reg;
  logic [7:0]         opcode_reg, txShift_reg, txByte;
  esr_op_t            op_reg, op_next;
  esr_susp_t          susp_reg, susp_next, eff;
  logic [LEN_W-1:0]   left_reg [3];
  logic [LEN_W-1:0]   opLen_reg;
  logic [IRQ_W-1:0]   irqStat_reg, irqMask_reg, events;
  logic [7:0]         lastCmd_reg;
  logic               armed_reg, waitReq_reg, irq_reg, miso_reg;
  logic [DATA_W-1:0]  rdData_reg;
  logic               sclkRise, sclkFall, csRise, cmdStrobe, done, accept;
  logic               startLoad;
  esr_op_t            startKind;

  function automatic logic [1:0] kindIdx(input esr_op_t k);
    case (k)
      ESR_ERASE: kindIdx = 2'd1;
      ESR_DIC:   kindIdx = 2'd2;
      default:   kindIdx = 2'd0;
    endcase
  endfunction

  function automatic logic [7:0] statusByte(input logic sel2, input logic busy, input esr_susp_t s);
    logic [7:0] b;
    b = 8'h00;
    if (sel2) begin
      b[PROG_BIT]  = s.prog;
      b[ERASE_BIT] = s.erase;
      b[DIC_BIT]   = s.dic;
    end else begin
      b[RDY_BIT] = busy;
    end
    statusByte = b;
  endfunction

  // Link inputs pass two flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
      sync2_reg <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
      prev_reg  <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
    end else begin
      sync1_reg <= spiIn;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign sclkRise  = sync2_reg.sclk & ~prev_reg.sclk & ~sync2_reg.csN;
  assign sclkFall  = ~sync2_reg.sclk & prev_reg.sclk & ~sync2_reg.csN;
  assign csRise    = sync2_reg.csN & ~prev_reg.csN;
  assign cmdStrobe = csRise && (bitCnt_reg >= OPC_BITS);

  // Opcode capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_reg <= 4'h0;
      opcode_reg <= 8'h00;
    end else if (sync2_reg.csN) begin
      bitCnt_reg <= 4'h0;
    end else if (sclkRise) begin
      if (bitCnt_reg < OPC_BITS) begin
        opcode_reg <= {opcode_reg[6:0], sync2_reg.mosi};
      end
      if (bitCnt_reg != CNT_MAX) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
    end
  end

  assign txByte = (opcode_reg == READ_STATUS1_CMD || opcode_reg == READ_STATUS2_CMD) ?
                  statusByte(opcode_reg == READ_STATUS2_CMD, op_reg != ESR_IDLE, susp_reg) : 8'h00;

  // Status byte shifted out after the opcode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_reg <= 8'h00;
      miso_reg    <= 1'b0;
    end else if (sync2_reg.csN) begin
      miso_reg <= 1'b0;
    end else if (sclkFall && bitCnt_reg == OPC_BITS) begin
      txShift_reg <= {txByte[6:0], 1'b0};
      miso_reg    <= txByte[7];
    end else if (sclkFall && bitCnt_reg > OPC_BITS) begin
      miso_reg    <= txShift_reg[7];
      txShift_reg <= {txShift_reg[6:0], 1'b0};
    end
  end

  assign done = (op_reg != ESR_IDLE) && (left_reg[kindIdx(op_reg)] == {{(LEN_W-1){1'b0}}, 1'b1});

  // Transaction decode and operation control
  always_comb begin
    esr_op_t cur;
    esr_susp_t cs;
    cur       = op_reg;
    cs        = susp_reg;
    events    = '0;
    accept    = 1'b0;
    startLoad = 1'b0;
    startKind = ESR_IDLE;
    if (done) begin
      unique case (op_reg)
        ESR_PROG:  cs.prog  = 1'b0;
        ESR_ERASE: cs.erase = 1'b0;
        ESR_DIC:   cs.dic   = 1'b0;
        default:   cs = cs;
      endcase
      cur = ESR_IDLE;
      events[IRQ_DONE] = 1'b1;
    end
    // A flag of the running kind means it was resumed, not suspended
    eff       = cs;
    eff.prog  = cs.prog & (cur != ESR_PROG);
    eff.erase = cs.erase & (cur != ESR_ERASE);
    eff.dic   = cs.dic & (cur != ESR_DIC);
    if (cmdStrobe) begin
      unique case (opcode_reg)
        SUSPEND_ALL_OPS_CMD, SUSPEND_PROG_ERASE_CMD: begin
          if (eff.prog || eff.dic) begin
            events[IRQ_REJECT] = 1'b1;
          end else if (cur == ESR_PROG || cur == ESR_ERASE ||
                       (cur == ESR_DIC && opcode_reg == SUSPEND_ALL_OPS_CMD)) begin
            cs.prog  = cs.prog | (cur == ESR_PROG);
            cs.erase = cs.erase | (cur == ESR_ERASE);
            cs.dic   = cs.dic | (cur == ESR_DIC);
            cur      = ESR_IDLE;
            accept   = 1'b1;
            events[IRQ_SUSP] = 1'b1;
          end else begin
            events[IRQ_IGNORE] = 1'b1;
          end
        end
        RESUME_ALL_OPS_CMD, RESUME_PROG_ERASE_CMD: begin
          if (cur != ESR_IDLE) begin
            events[IRQ_IGNORE] = 1'b1;
          end else if (eff.prog) begin
            cur    = ESR_PROG;
            accept = 1'b1;
          end else if (eff.erase) begin
            cur    = ESR_ERASE;
            accept = 1'b1;
          end else if (eff.dic && opcode_reg == RESUME_ALL_OPS_CMD) begin
            cur    = ESR_DIC;
            accept = 1'b1;
          end else begin
            events[IRQ_IGNORE] = 1'b1;
          end
        end
        PROGRAM_CMD: begin
          if (cur != ESR_IDLE || eff.prog || eff.dic) begin
            events[IRQ_REJECT] = 1'b1;
          end else begin
            cur = ESR_PROG;
            startLoad = 1'b1;
            startKind = ESR_PROG;
            accept    = 1'b1;
          end
        end
        SECTOR_ERASE_CMD, INTEGRITY_CHECK_CMD: begin
          if (cur != ESR_IDLE || (|cs)) begin
            events[IRQ_IGNORE] = 1'b1;
          end else begin
            cur       = (opcode_reg == SECTOR_ERASE_CMD) ? ESR_ERASE : ESR_DIC;
            startLoad = 1'b1;
            startKind = cur;
            accept    = 1'b1;
          end
        end
        WRITE_REG_CMD, PPB_ERASE_CMD: begin
          if (|cs) begin
            events[IRQ_REJECT] = 1'b1;
          end else begin
            accept = 1'b1;
          end
        end
        SOFT_RESET_ENABLE_CMD, LEARNING_PATTERN_READ_CMD, READ_STATUS1_CMD, READ_STATUS2_CMD: begin
          accept = 1'b1;
        end
        READ_DYNAMIC_PROTECT_CMD: begin
          accept = !eff.prog;
          events[IRQ_REJECT] = eff.prog;
        end
        FAST_READ_SHORT_CMD, FAST_READ_LONG_CMD: begin
          accept = !eff.dic;
          events[IRQ_REJECT] = eff.dic;
        end
        QUAD_IDENTITY_READ_CMD: begin
          accept = !(eff.prog || eff.dic);
          events[IRQ_REJECT] = eff.prog || eff.dic;
        end
        default: begin
          events[IRQ_IGNORE] = 1'b1;
        end
      endcase
    end
    op_next   = cur;
    susp_next = cs;
  end

  // Operation state and suspend flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_reg   <= ESR_IDLE;
      susp_reg <= '0;
    end else begin
      op_reg   <= op_next;
      susp_reg <= susp_next;
    end
  end

  // Work left per kind, kept across a suspend
  for (genvar k = 0; k < 3; k++) begin : g_left
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        left_reg[k] <= '0;
      end else if (startLoad && kindIdx(startKind) == 2'(k)) begin
        left_reg[k] <= opLen_reg;
      end else if (op_reg != ESR_IDLE && kindIdx(op_reg) == 2'(k) && !done) begin
        left_reg[k] <= left_reg[k] - {{(LEN_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Last accepted opcode and software reset arming
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastCmd_reg <= 8'h00;
      armed_reg   <= 1'b0;
    end else if (cmdStrobe) begin
      armed_reg <= accept && opcode_reg == SOFT_RESET_ENABLE_CMD;
      if (accept) begin
        lastCmd_reg <= opcode_reg;
      end
    end
  end

  // Avalon-MM slave: one wait cycle on every access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitReq_reg <= 1'b1;
      rdData_reg  <= '0;
    end else begin
      waitReq_reg <= !((avs_read || avs_write) && waitReq_reg);
      if (avs_read && waitReq_reg) begin
        rdData_reg <= '0;
        unique case (avs_address)
          REG_STATUS1: rdData_reg[RDY_BIT] <= op_reg != ESR_IDLE;
          REG_STATUS2: begin
            rdData_reg[PROG_BIT]  <= susp_reg.prog;
            rdData_reg[ERASE_BIT] <= susp_reg.erase;
            rdData_reg[DIC_BIT]   <= susp_reg.dic;
          end
          REG_IRQSTAT: rdData_reg[IRQ_W-1:0] <= irqStat_reg;
          REG_IRQMASK: rdData_reg[IRQ_W-1:0] <= irqMask_reg;
          REG_OPLEN:   rdData_reg[LEN_W-1:0] <= opLen_reg;
          REG_LASTCMD: rdData_reg[ARMED_BIT:0] <= {armed_reg, lastCmd_reg};
          default:     rdData_reg <= '0;
        endcase
      end
    end
  end

  // Writable registers, sticky events set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_reg <= '0;
      irqMask_reg <= MASK_RST;
      opLen_reg   <= LEN_W'(OPLEN_RST);
      irq_reg     <= 1'b0;
    end else begin
      if (avs_write && !waitReq_reg && avs_address == REG_IRQSTAT) begin
        irqStat_reg <= (irqStat_reg & ~avs_writedata[IRQ_W-1:0]) | events;
      end else begin
        irqStat_reg <= irqStat_reg | events;
      end
      if (avs_write && !waitReq_reg && avs_address == REG_IRQMASK) begin
        irqMask_reg <= avs_writedata[IRQ_W-1:0];
      end
      if (avs_write && !waitReq_reg && avs_address == REG_OPLEN) begin
        opLen_reg <= avs_writedata[LEN_W-1:0];
      end
      irq_reg <= |(irqStat_reg & irqMask_reg);
    end
  end

  assign avs_readdata    = rdData_reg;
  assign avs_waitrequest = waitReq_reg;
  assign spiMiso         = miso_reg;
  assign irq             = irq_reg;
endmodule
`default_nettype wire

/* File: esr_suspend_resume_monitor.sv */
/*
  Checker for the register port and status read fields of the suspend/resume sequencer.
  Assumes it sees only the top ports; bound to every instance below.
*/
`timescale 1ns/1ps
`default_nettype none
module esr_suspend_resume_monitor
  import esr_pkg::*;
#(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       arst_n,
  // Register port
  input wire logic [esr_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [esr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [esr_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  // Interrupt
  input wire logic                       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic rdOk = avs_read && !avs_waitrequest;

  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than one cycle");
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("wait request low without a request");
  chk_read_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (rdOk && avs_address > 5'h14 |-> avs_readdata == '0)
    else $error("unmapped address read nonzero");
  chk_status_one: assert property (rdOk && avs_address == REG_STATUS1 |-> avs_readdata[31:1] == '0)
    else $error("status one has bits beside busy");
  chk_status_two: assert property (rdOk && avs_address == REG_STATUS2 |-> (avs_readdata & ~32'h0000_0013) == '0)
    else $error("status two has bits beside suspend flags");
  chk_mask_quiet: assert property (avs_write && !avs_waitrequest && avs_address == REG_IRQMASK
    && avs_writedata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
endmodule

bind esr_suspend_resume esr_suspend_resume_monitor #(.LEN_W(LEN_W)) esr_suspend_resume_monitor_i (
  .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
`default_nettype wire

/* File: esr_spi_host.sv */
/*
  Behavioural serial host: sends one opcode frame per request, mode 0, MSB first.
  Assumes a level request that is held until ack rises; link clock of 80 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module esr_spi_host (
  // Request handshake
  input  wire logic             req,
  input  wire logic [7:0]       opc,
  input  wire logic             rd,
  output var  logic             ack,
  output var  logic [7:0]       rx,
  // Link
  output var  esr_pkg::esr_spi_t spiOut,
  input  wire logic             miso
);
  import esr_pkg::*;
  logic [15:0] sh;
  initial begin
    spiOut = '{sclk: 1'b0, csN: 1'b1, mosi: 1'b1};
    ack = 1'b0;
    rx = '0;
    forever begin
      wait (req);
      #3;
      sh = {opc, 8'h00};
      spiOut.csN = 1'b0;
      for (int i = 0; i < (rd ? 16 : 8); i++) begin
        spiOut.mosi = sh[15];
        #40;
        spiOut.sclk = 1'b1;
        rx = {rx[6:0], miso};
        sh = sh << 1;
        #40;
        spiOut.sclk = 1'b0;
      end
      #40;
      spiOut.csN = 1'b1;
      spiOut.mosi = ~spiOut.mosi;
      #400;
      ack = 1'b1;
      wait (!req);
      ack = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: esr_suspend_resume_tb_top.sv */
/*
  Self-checking bench of the suspend/resume sequencer: register port tasks and serial frames.
  Assumes the monitor is bound and the serial host model drives the link.
*/
`timescale 1ns/1ps
`default_nettype none
module esr_suspend_resume_tb_top;
  import esr_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} esr_exp_t;
  logic clk = 1'b0, arstN = 1'b0, rd = 1'b0, wr = 1'b0, req = 1'b0, rdb = 1'b0;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, seed = 32'h0000_0013;
  logic [7:0] opc = '0;
  wire logic [31:0] rdata;
  wire logic wreq, miso, irq;
  logic ack;
  logic [7:0] rx;
  esr_spi_t spi;
  esr_exp_t expQ[$];
  int errTotal = 0, checked = 0;
  logic [7:0] okP [4] = '{FAST_READ_SHORT_CMD, FAST_READ_LONG_CMD, LEARNING_PATTERN_READ_CMD, SOFT_RESET_ENABLE_CMD};

  esr_suspend_resume #(.LEN_W(16)) esr_suspend_resume_i (.clk(clk), .arst_n(arstN), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .spiIn(spi), .spiMiso(miso), .irq(irq));
  esr_spi_host esr_spi_host_i (.req(req), .opc(opc), .rd(rdb), .ack(ack), .rx(rx), .spiOut(spi), .miso(miso));

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errTotal++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdx(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    expQ.push_back('{e & m, m});
    bus(1'b0, a, '0, q);
  endtask

  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic cmd(input logic [7:0] o, input logic r = 1'b0);
    @(posedge clk);
    opc <= o;
    rdb <= r;
    req <= 1'b1;
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    req <= 1'b0;
    while (ack !== 1'b0) begin
      @(posedge clk);
    end
  endtask

  task automatic idle_wait();
    logic [31:0] q = 32'h0000_0001;
    int n = 0;
    while (q[0] !== 1'b0 && n < 400) begin
      expQ.push_back('{32'h0000_0000, 32'h0000_0000});
      bus(1'b0, REG_STATUS1, '0, q);
      n++;
    end
    chk(q, 32'h0000_0000);
  endtask

  // Result watcher: each completed read takes the oldest note
  always @(posedge clk) begin
    esr_exp_t x;
    if (rd && wreq === 1'b0 && expQ.size() > 0) begin
      x = expQ.pop_front();
      if (x.m != 0) chk(rdata & x.m, x.e);
    end
  end

  initial begin
    #200000;
    errTotal++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    arstN <= 1'b1;
    rdx(REG_OPLEN, 32'h0000_0100);
    rdx(REG_IRQMASK, 32'h0000_0000);
    rdx(5'h18, 32'h0000_0000);
    wrr(REG_STATUS1, 32'h0000_0001);
    rdx(REG_STATUS1, 32'h0000_0000);
    seed = xs(seed);
    wrr(REG_OPLEN, 32'h0000_0140 | seed[5:0]);
    cmd(RESUME_ALL_OPS_CMD);
    rdx(REG_STATUS2, 32'h0000_0000);
    rdx(REG_IRQSTAT, 32'h0000_0004);
    wrr(REG_IRQSTAT, 32'h0000_000F);
    $display("test idle resume done");
    cmd(PROGRAM_CMD);
    rdx(REG_STATUS1, 32'h0000_0001);
    cmd(SUSPEND_PROG_ERASE_CMD);
    rdx(REG_STATUS2, 32'h0000_0001);
    cmd(SUSPEND_ALL_OPS_CMD);
    rdx(REG_IRQSTAT, 32'h0000_0002, 32'h0000_0002);
    cmd(READ_STATUS2_CMD, 1'b1);
    chk({24'h00_0000, rx}, 32'h0000_0001);
    foreach (okP[i]) begin
      cmd(okP[i]);
      rdx(REG_LASTCMD, {24'h00_0000, okP[i]}, 32'h0000_00FF);
    end
    cmd(SECTOR_ERASE_CMD);
    cmd(WRITE_REG_CMD);
    cmd(PPB_ERASE_CMD);
    rdx(REG_LASTCMD, {24'h00_0000, SOFT_RESET_ENABLE_CMD}, 32'h0000_00FF);
    rdx(REG_STATUS2, 32'h0000_0001);
    cmd(RESUME_PROG_ERASE_CMD);
    rdx(REG_STATUS1, 32'h0000_0001);
    cmd(SUSPEND_PROG_ERASE_CMD);
    rdx(REG_STATUS1, 32'h0000_0000);
    wrr(REG_IRQSTAT, 32'h0000_000F);
    wrr(REG_IRQMASK, 32'h0000_0001);
    cmd(RESUME_ALL_OPS_CMD);
    idle_wait();
    rdx(REG_STATUS2, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    wrr(REG_IRQMASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wrr(REG_IRQMASK, 32'h0000_0001);
    wrr(REG_IRQSTAT, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test program suspend done");
    cmd(SECTOR_ERASE_CMD);
    cmd(SUSPEND_ALL_OPS_CMD);
    cmd(QUAD_IDENTITY_READ_CMD);
    rdx(REG_LASTCMD, {24'h00_0000, QUAD_IDENTITY_READ_CMD}, 32'h0000_00FF);
    cmd(PROGRAM_CMD);
    cmd(SUSPEND_PROG_ERASE_CMD);
    rdx(REG_STATUS2, 32'h0000_0003);
    cmd(RESUME_PROG_ERASE_CMD);
    idle_wait();
    rdx(REG_STATUS2, 32'h0000_0002);
    cmd(RESUME_ALL_OPS_CMD);
    cmd(READ_STATUS1_CMD, 1'b1);
    chk({24'h00_0000, rx}, 32'h0000_0001);
    idle_wait();
    rdx(REG_STATUS2, 32'h0000_0000);
    $display("test erase suspend done");
    cmd(INTEGRITY_CHECK_CMD);
    cmd(SUSPEND_PROG_ERASE_CMD);
    rdx(REG_STATUS1, 32'h0000_0001);
    cmd(SUSPEND_ALL_OPS_CMD);
    rdx(REG_STATUS2, 32'h0000_0010);
    cmd(READ_DYNAMIC_PROTECT_CMD);
    rdx(REG_LASTCMD, {24'h00_0000, READ_DYNAMIC_PROTECT_CMD}, 32'h0000_00FF);
    cmd(RESUME_PROG_ERASE_CMD);
    rdx(REG_STATUS1, 32'h0000_0000);
    cmd(RESUME_ALL_OPS_CMD);
    rdx(REG_STATUS1, 32'h0000_0001);
    idle_wait();
    rdx(REG_STATUS2, 32'h0000_0000);
    $display("test check suspend done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
